/* hdl/dual_port_i2c_map.svh */
// Constants for the dual-port serial target: addresses, filter timing, codes
`ifndef DUAL_PORT_I2C_MAP_SVH
`define DUAL_PORT_I2C_MAP_SVH

// Target addresses selected by the strap connection
`define TGT_ADDR_GND        7'h60
`define TGT_ADDR_IO_SUPPLY  7'h61
`define TGT_ADDR_DATA_LINE  7'h62
`define TGT_ADDR_CLOCK_LINE 7'h63

// Core clock period, 40 MHz
`define CLK_PERIOD_PS       25000

// Spike widths suppressed on clock and data inputs
`define SPIKE_FS_NS         50
`define SPIKE_HS_NS         10
// Least times round up to whole cycles, never below one
`define SPIKE_FS_CYC ((((`SPIKE_FS_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS) < 1 ? 1 : \
  ((((`SPIKE_FS_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)))
`define SPIKE_HS_CYC ((((`SPIKE_HS_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS) < 1 ? 1 : \
  ((((`SPIKE_HS_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)))

// Host wait after the I/O supply rises, kept by the host
`define HOST_WAKE_US        500

// High-speed master code prefix, upper five bits of the address byte
`define MASTER_CODE_PREFIX  5'h01
// Last bit position inside a byte
`define LAST_BIT            3'h7
// Filter counter width
`define FILT_CNT_W          4

`endif

/* hdl/dual_port_i2c_pkg.sv */
// Types shared by the dual-port serial target
`default_nettype none
package dual_port_i2c_pkg;

  // Per-port transfer state, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_RECV = 6'h04,
    ST_ACK  = 6'h08,
    ST_SEND = 6'h10,
    ST_RACK = 6'h20
  } tgt_state_t;

  // Where the address strap is tied
  typedef enum logic [1:0] {
    STRAP_GND        = 2'h0,
    STRAP_IO_SUPPLY  = 2'h1,
    STRAP_DATA_LINE  = 2'h2,
    STRAP_CLOCK_LINE = 2'h3
  } strap_conn_t;

endpackage
`default_nettype wire

/* hdl/dual_port_i2c_target.sv */
// Dual-port serial target front end with strap-selected shared address
`timescale 1ns/10ps
`default_nettype none
`include "dual_port_i2c_map.svh"
module dual_port_i2c_target #(
  parameter int INDEX_W = 8
) (
  input  wire logic               CORE_CLK_IN,
  input  wire logic               RST_B_IN,
  input  wire logic               ADDR_STRAP_IN,
  input  wire logic               SYSTEM_BUS_CLOCK_LINE_IN,
  input  wire logic               SYSTEM_BUS_DATA_LINE_IN,
  output logic                    SYSTEM_BUS_DATA_LINE_OUT,
  output logic                    SYSTEM_BUS_DATA_LINE_OE_OUT,
  input  wire logic               VOLTAGE_SCALING_BUS_CLOCK_LINE_IN,
  input  wire logic               VOLTAGE_SCALING_BUS_DATA_LINE_IN,
  output logic                    VOLTAGE_SCALING_BUS_DATA_LINE_OUT,
  output logic                    VOLTAGE_SCALING_BUS_DATA_LINE_OE_OUT,
  output logic [1:0]              REG_WR_OUT,
  output logic [1:0]              REG_RD_OUT,
  output logic [2*INDEX_W-1:0]    REG_INDEX_OUT,
  output logic [15:0]             REG_WDATA_OUT,
  input  wire logic [15:0]        REG_RDATA_IN,
  output logic [6:0]              TARGET_ADDR_OUT
);

  // Index is taken from one received byte
  initial
  begin
    if (INDEX_W < 1 || INDEX_W > 8)
      $error("dual_port_i2c_target: INDEX_W must be 1 to 8");
  end

  // Strap connection to address
  function automatic logic [6:0] strap_addr(input dual_port_i2c_pkg::strap_conn_t conn);
    case (conn)
      dual_port_i2c_pkg::STRAP_GND:        strap_addr = `TGT_ADDR_GND;
      dual_port_i2c_pkg::STRAP_IO_SUPPLY:  strap_addr = `TGT_ADDR_IO_SUPPLY;
      dual_port_i2c_pkg::STRAP_DATA_LINE:  strap_addr = `TGT_ADDR_DATA_LINE;
      dual_port_i2c_pkg::STRAP_CLOCK_LINE: strap_addr = `TGT_ADDR_CLOCK_LINE;
      default:                             strap_addr = `TGT_ADDR_GND;
    endcase
  endfunction

  logic [1:0]        scl_pin;
  logic [1:0]        sda_pin;
  logic [1:0]        sda_v;
  logic [1:0]        strap_dly_reg;
  logic [1:0]        fall_v;
  logic [1:0]        start_v;
  logic [1:0]        stop_v;
  logic [1:0]        scl_v;
  logic [1:0]        oe_v;
  logic [1:0]        wr_v;
  logic [1:0]        rd_v;
  logic [6:0]        tgt_addr_reg;
  logic              strap_s1_reg;
  logic              strap_s2_reg;
  logic              strap_idle_reg;
  logic              strap_start_reg;
  logic              sense_pend_reg;
  logic              drive_low_reg;
  dual_port_i2c_pkg::strap_conn_t conn;

  assign scl_pin = {VOLTAGE_SCALING_BUS_CLOCK_LINE_IN, SYSTEM_BUS_CLOCK_LINE_IN};
  assign sda_pin = {VOLTAGE_SCALING_BUS_DATA_LINE_IN, SYSTEM_BUS_DATA_LINE_IN};

  // Strap synchroniser
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      strap_s1_reg  <= 1'b0;
      strap_s2_reg  <= 1'b0;
      strap_dly_reg <= 2'h0;
    end
    else
    begin
      strap_s1_reg <= ADDR_STRAP_IN;
      strap_s2_reg <= strap_s1_reg;
      // Delayed copy never leads the filtered lines, so idle never sees a new level
      strap_dly_reg <= {strap_dly_reg[0], strap_s2_reg};
    end
  end

  // Strap classification: level at idle, at start, at first clock low
  always_comb
  begin
    if (!strap_idle_reg)
      conn = dual_port_i2c_pkg::STRAP_GND;
    else if (!strap_start_reg)
      conn = dual_port_i2c_pkg::STRAP_DATA_LINE;
    else if (!strap_s2_reg)
      conn = dual_port_i2c_pkg::STRAP_CLOCK_LINE;
    else
      conn = dual_port_i2c_pkg::STRAP_IO_SUPPLY;
  end

  // Address sensing on system-bus starts; the raw strap leads the filtered
  // lines, so idle uses the delayed copy and the start level the raw one
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      strap_idle_reg  <= 1'b0;
      strap_start_reg <= 1'b0;
      sense_pend_reg  <= 1'b0;
      tgt_addr_reg    <= `TGT_ADDR_GND;
    end
    else
    begin
      if (scl_v[0] && sda_v[0] && !start_v[0])
        strap_idle_reg <= strap_dly_reg[1];
      if (start_v[0])
      begin
        strap_start_reg <= strap_s2_reg;
        sense_pend_reg  <= 1'b1;
      end
      else if (stop_v[0])
        sense_pend_reg <= 1'b0;
      else if (sense_pend_reg && fall_v[0])
      begin
        sense_pend_reg <= 1'b0;
        tgt_addr_reg   <= strap_addr(conn);
      end
    end
  end

  // Open-drain data only ever pulls low
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      drive_low_reg <= 1'b0;
    else
      drive_low_reg <= 1'b0;
  end

  // Identical engine on both ports; no speed handshake gates it
  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_port
      line_filter_if lf ();
      dual_port_i2c_pkg::tgt_state_t state_reg;
      logic [2:0]         bit_reg;
      logic [7:0]         shift_reg;
      logic [7:0]         tx_reg;
      logic [7:0]         wdata_reg;
      logic [INDEX_W-1:0] index_reg;
      logic               have_index_reg;
      logic               data_byte_reg;
      logic               rw_reg;
      logic               flag_reg;
      logic               oe_reg;
      logic               wr_reg;
      logic               rd_reg;
      logic               hs_reg;
      logic [7:0]         byte_in;
      logic [7:0]         rdata;

      i2c_line_filter u_filt (
        .clk_in     (CORE_CLK_IN),
        .rst_b_in   (RST_B_IN),
        .scl_pin_in (scl_pin[p]),
        .sda_pin_in (sda_pin[p]),
        .lf         (lf.filt)
      );

      assign lf.hs_mode = hs_reg;
      assign byte_in    = {shift_reg[6:0], lf.sda};
      assign rdata      = REG_RDATA_IN[8*p +: 8];
      assign scl_v[p]   = lf.scl;
      assign sda_v[p]   = lf.sda;
      assign fall_v[p]  = lf.scl_fall;
      assign start_v[p] = lf.start;
      assign stop_v[p]  = lf.stop;
      assign oe_v[p]    = oe_reg;
      assign wr_v[p]    = wr_reg;
      assign rd_v[p]    = rd_reg;
      assign REG_INDEX_OUT[INDEX_W*p +: INDEX_W] = index_reg;
      assign REG_WDATA_OUT[8*p +: 8]             = wdata_reg;

      // Transfer engine; start and stop override any state
      always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
      begin
        if (!RST_B_IN)
        begin
          state_reg      <= dual_port_i2c_pkg::ST_IDLE;
          bit_reg        <= 3'h0;
          shift_reg      <= 8'h00;
          tx_reg         <= 8'h00;
          wdata_reg      <= 8'h00;
          index_reg      <= '0;
          have_index_reg <= 1'b0;
          data_byte_reg  <= 1'b0;
          rw_reg         <= 1'b0;
          flag_reg       <= 1'b0;
          oe_reg         <= 1'b0;
          wr_reg         <= 1'b0;
          rd_reg         <= 1'b0;
          hs_reg         <= 1'b0;
        end
        else
        begin
          wr_reg <= 1'b0;
          rd_reg <= 1'b0;
          if (lf.stop)
          begin
            state_reg <= dual_port_i2c_pkg::ST_IDLE;
            oe_reg    <= 1'b0;
            hs_reg    <= 1'b0;
          end
          else if (lf.start)
          begin
            state_reg      <= dual_port_i2c_pkg::ST_ADDR;
            bit_reg        <= 3'h0;
            oe_reg         <= 1'b0;
            have_index_reg <= 1'b0; // Index kept across repeated start
          end
          else
          begin
            case (state_reg)
              dual_port_i2c_pkg::ST_IDLE: ;
              dual_port_i2c_pkg::ST_ADDR:
                if (lf.scl_rise)
                begin
                  shift_reg <= byte_in;
                  bit_reg   <= bit_reg + 3'h1;
                  if (bit_reg == `LAST_BIT)
                  begin
                    if (byte_in[7:1] == tgt_addr_reg)
                    begin
                      rw_reg        <= byte_in[0];
                      rd_reg        <= byte_in[0];
                      data_byte_reg <= 1'b0;
                      flag_reg      <= 1'b0;
                      state_reg     <= dual_port_i2c_pkg::ST_ACK;
                    end
                    else
                    begin
                      // Master code only shortens the filter, never acked
                      if (byte_in[7:3] == `MASTER_CODE_PREFIX)
                        hs_reg <= 1'b1;
                      state_reg <= dual_port_i2c_pkg::ST_IDLE;
                    end
                  end
                end
              dual_port_i2c_pkg::ST_RECV:
                if (lf.scl_rise)
                begin
                  shift_reg <= byte_in;
                  bit_reg   <= bit_reg + 3'h1;
                  if (bit_reg == `LAST_BIT)
                  begin
                    data_byte_reg <= have_index_reg;
                    flag_reg      <= 1'b0;
                    state_reg     <= dual_port_i2c_pkg::ST_ACK;
                    if (!have_index_reg)
                    begin
                      index_reg      <= byte_in[INDEX_W-1:0];
                      have_index_reg <= 1'b1;
                    end
                    else
                    begin
                      wdata_reg <= byte_in;
                      wr_reg    <= 1'b1;
                    end
                  end
                end
              dual_port_i2c_pkg::ST_ACK:
                if (lf.scl_fall)
                begin
                  if (!flag_reg)
                  begin
                    oe_reg   <= 1'b1;
                    flag_reg <= 1'b1;
                  end
                  else
                  begin
                    flag_reg <= 1'b0;
                    bit_reg  <= 3'h0;
                    if (rw_reg)
                    begin
                      tx_reg    <= rdata;
                      oe_reg    <= ~rdata[7];
                      state_reg <= dual_port_i2c_pkg::ST_SEND;
                    end
                    else
                    begin
                      oe_reg    <= 1'b0;
                      state_reg <= dual_port_i2c_pkg::ST_RECV;
                      if (data_byte_reg)
                        index_reg <= index_reg + 1'b1;
                    end
                  end
                end
              dual_port_i2c_pkg::ST_SEND:
                if (lf.scl_rise)
                begin
                  bit_reg <= bit_reg + 3'h1;
                  if (bit_reg == `LAST_BIT)
                  begin
                    flag_reg  <= 1'b0;
                    state_reg <= dual_port_i2c_pkg::ST_RACK;
                  end
                end
                else if (lf.scl_fall)
                begin
                  tx_reg <= {tx_reg[6:0], 1'b0};
                  oe_reg <= ~tx_reg[6];
                end
              dual_port_i2c_pkg::ST_RACK:
                // Host ack fetches the next index; a nack ends the read
                if (lf.scl_rise)
                begin
                  if (!lf.sda)
                  begin
                    flag_reg  <= 1'b1;
                    index_reg <= index_reg + 1'b1;
                    rd_reg    <= 1'b1;
                  end
                  else
                    state_reg <= dual_port_i2c_pkg::ST_IDLE;
                end
                else if (lf.scl_fall)
                begin
                  if (flag_reg)
                  begin
                    flag_reg  <= 1'b0;
                    bit_reg   <= 3'h0;
                    tx_reg    <= rdata;
                    oe_reg    <= ~rdata[7];
                    state_reg <= dual_port_i2c_pkg::ST_SEND;
                  end
                  else
                    oe_reg <= 1'b0;
                end
              default:
                state_reg <= dual_port_i2c_pkg::ST_IDLE;
            endcase
          end
        end
      end
    end
  endgenerate

  // Top outputs are all flop-driven
  assign SYSTEM_BUS_DATA_LINE_OUT             = drive_low_reg;
  assign VOLTAGE_SCALING_BUS_DATA_LINE_OUT    = drive_low_reg;
  assign SYSTEM_BUS_DATA_LINE_OE_OUT          = oe_v[0];
  assign VOLTAGE_SCALING_BUS_DATA_LINE_OE_OUT = oe_v[1];
  assign REG_WR_OUT                           = wr_v;
  assign REG_RD_OUT                           = rd_v;
  assign TARGET_ADDR_OUT                      = tgt_addr_reg;

endmodule // dual_port_i2c_target
`default_nettype wire

/* hdl/i2c_line_filter.sv */
// Synchroniser, spike filter and event detector for one clock/data pair
`timescale 1ns/10ps
`default_nettype none
`include "dual_port_i2c_map.svh"
module i2c_line_filter #(
  parameter int FS_CYC = `SPIKE_FS_CYC,
  parameter int HS_CYC = `SPIKE_HS_CYC
) (
  input  wire logic   clk_in,
  input  wire logic   rst_b_in,
  input  wire logic   scl_pin_in,
  input  wire logic   sda_pin_in,
  line_filter_if.filt lf
);

  // Counter must hold the longest filter length
  initial
  begin
    if (FS_CYC < 1 || HS_CYC < 1 || FS_CYC >= (1 << `FILT_CNT_W) || HS_CYC >= (1 << `FILT_CNT_W))
      $error("i2c_line_filter: filter length out of range");
  end

  logic [1:0]                 raw;
  logic [1:0]                 clean;
  logic [1:0]                 clean_d_reg;
  logic [`FILT_CNT_W-1:0]     limit;

  assign raw   = {sda_pin_in, scl_pin_in};
  // Shorter filter once the port runs high speed
  assign limit = lf.hs_mode ? HS_CYC[`FILT_CNT_W-1:0] : FS_CYC[`FILT_CNT_W-1:0];

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_line
      logic                   sync1_reg;
      logic                   sync2_reg;
      logic                   clean_reg;
      logic [`FILT_CNT_W-1:0] cnt_reg;

      // Two-stage synchroniser, idle bus is high
      always_ff @(posedge clk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
        begin
          sync1_reg <= 1'b1;
          sync2_reg <= 1'b1;
        end
        else
        begin
          sync1_reg <= raw[i];
          sync2_reg <= sync1_reg;
        end
      end

      // New level accepted only after it persists for the limit
      always_ff @(posedge clk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
        begin
          clean_reg <= 1'b1;
          cnt_reg   <= '0;
        end
        else if (sync2_reg == clean_reg)
          cnt_reg <= '0;
        else if (cnt_reg + 1'b1 >= limit)
        begin
          clean_reg <= sync2_reg;
          cnt_reg   <= '0;
        end
        else
          cnt_reg <= cnt_reg + 1'b1;
      end

      assign clean[i] = clean_reg;
    end
  endgenerate

  // Previous filtered levels for edge detection
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      clean_d_reg <= 2'b11;
    else
      clean_d_reg <= clean;
  end

  // Events: start and stop are data edges while clock stays high
  assign lf.scl      = clean[0];
  assign lf.sda      = clean[1];
  assign lf.scl_rise = clean[0] & ~clean_d_reg[0];
  assign lf.scl_fall = ~clean[0] & clean_d_reg[0];
  assign lf.start    = clean[0] & clean_d_reg[0] & ~clean[1] & clean_d_reg[1];
  assign lf.stop     = clean[0] & clean_d_reg[0] & clean[1] & ~clean_d_reg[1];

endmodule // i2c_line_filter
`default_nettype wire

/* hdl/line_filter_if.sv */
// Filtered clock/data lines and bus events of one target port
`timescale 1ns/10ps
`default_nettype none
interface line_filter_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic hs_mode;

  modport filt (output scl, output sda, output scl_rise, output scl_fall,
                output start, output stop, input hs_mode);
  modport core (input scl, input sda, input scl_rise, input scl_fall,
                input start, input stop, output hs_mode);
endinterface
`default_nettype wire

/* verif/dual_port_i2c_properties.sv */
// Port-level checker for the dual-port serial target
`timescale 1ns/10ps
`default_nettype none
module dual_port_i2c_properties (
  input wire logic       CORE_CLK_IN,
  input wire logic       RST_B_IN,
  input wire logic       SYSTEM_BUS_CLOCK_LINE_IN,
  input wire logic       SYSTEM_BUS_DATA_LINE_IN,
  input wire logic       SYSTEM_BUS_DATA_LINE_OE_OUT,
  input wire logic       VOLTAGE_SCALING_BUS_DATA_LINE_OE_OUT,
  input wire logic [1:0] REG_WR_OUT,
  input wire logic [1:0] REG_RD_OUT,
  input wire logic [6:0] TARGET_ADDR_OUT
);
  logic       sda_prev_reg;
  logic [7:0] since_start_reg;

  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  // Cycles since a raw start; saturates so a stale count never wraps
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN)
    if (!RST_B_IN)
    begin
      sda_prev_reg    <= 1'b1;
      since_start_reg <= 8'hff;
    end
    else
    begin
      sda_prev_reg <= SYSTEM_BUS_DATA_LINE_IN;
      if (SYSTEM_BUS_CLOCK_LINE_IN && sda_prev_reg && !SYSTEM_BUS_DATA_LINE_IN)
        since_start_reg <= 8'h00;
      else if (since_start_reg != 8'hff)
        since_start_reg <= since_start_reg + 8'h01;
    end

  property p_addr_range; TARGET_ADDR_OUT[6:2] == 5'h18; endproperty
  a_addr_range: assert property (p_addr_range)
    else $error("Address outside strap set");
  property p_addr_at_start; $changed(TARGET_ADDR_OUT) |-> since_start_reg < 8'hf0; endproperty
  a_addr_at_start: assert property (p_addr_at_start)
    else $error("Address moved away from a start");
  property p_sys_ack; REG_WR_OUT[0] |-> ##[1:300] SYSTEM_BUS_DATA_LINE_OE_OUT; endproperty
  a_sys_ack: assert property (p_sys_ack)
    else $error("No ack after system write");
  property p_vs_ack;
    REG_WR_OUT[1] |-> ##[1:300] VOLTAGE_SCALING_BUS_DATA_LINE_OE_OUT;
  endproperty
  a_vs_ack: assert property (p_vs_ack)
    else $error("No ack after scaling write");
  property p_rd_pulse; REG_RD_OUT[1] |=> !REG_RD_OUT[1]; endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("Read request longer than one cycle");
  property p_sys_oe; $rose(SYSTEM_BUS_DATA_LINE_OE_OUT) |-> SYSTEM_BUS_DATA_LINE_OE_OUT[*3]; endproperty
  a_sys_oe: assert property (p_sys_oe)
    else $error("System drive too short");
  property p_vs_oe;
    $rose(VOLTAGE_SCALING_BUS_DATA_LINE_OE_OUT) |-> VOLTAGE_SCALING_BUS_DATA_LINE_OE_OUT[*3];
  endproperty
  a_vs_oe: assert property (p_vs_oe)
    else $error("Scaling drive too short");
  // A write is only counted on a clock level that really stood
  property p_spike; REG_WR_OUT[0] |-> $past(SYSTEM_BUS_CLOCK_LINE_IN, 3); endproperty
  a_spike: assert property (p_spike)
    else $error("Write without a settled clock high");
endmodule // dual_port_i2c_properties

bind dual_port_i2c_target dual_port_i2c_properties u_props (
  .CORE_CLK_IN(CORE_CLK_IN), .RST_B_IN(RST_B_IN),
  .SYSTEM_BUS_CLOCK_LINE_IN(SYSTEM_BUS_CLOCK_LINE_IN),
  .SYSTEM_BUS_DATA_LINE_IN(SYSTEM_BUS_DATA_LINE_IN),
  .SYSTEM_BUS_DATA_LINE_OE_OUT(SYSTEM_BUS_DATA_LINE_OE_OUT),
  .VOLTAGE_SCALING_BUS_DATA_LINE_OE_OUT(VOLTAGE_SCALING_BUS_DATA_LINE_OE_OUT),
  .REG_WR_OUT(REG_WR_OUT), .REG_RD_OUT(REG_RD_OUT), .TARGET_ADDR_OUT(TARGET_ADDR_OUT)
);
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the dual-port serial target
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        core_clk     = 1'b0;
  logic        rst_b        = 1'b0;
  logic [1:0]  strap_mode   = 2'h0;
  logic [15:0] rdata        = 16'h0000;
  logic [31:0] rnd_state    = 32'ha4f1;
  logic [7:0]  key          = 8'h00;
  logic [7:0]  got;
  logic [6:0]  addr;
  int          err_total    = 0;
  int          total_checks = 0;
  int          rd_cnt[2]    = '{0, 0};
  int          half_tab[3]  = '{100, 1250, 5000};
  logic [23:0] wr_q[$];
  logic [7:0]  rd_q[$];
  event        got_ev;
  wire  [1:0]  scl, host_low, oe, wr, rd, dout;
  // Pull-up bus: low when the host pulls or the target drives its data level low
  wire  [1:0]  sda_wire = ~host_low & ~(oe & ~dout);
  wire  [15:0] idx_o, wdata;
  wire  [6:0]  taddr;
  // Strap tied to ground, supply, system data or system clock
  wire         strap = strap_mode[1] ? (strap_mode[0] ? scl[0] : sda_wire[0]) : strap_mode[0];

  always #12.5 core_clk = ~core_clk;

  two_bus_host_model host (.scl_out(scl), .sda_low_out(host_low), .sda_in(sda_wire));

  dual_port_i2c_target #(.INDEX_W(8)) DUT (
    .CORE_CLK_IN(core_clk), .RST_B_IN(rst_b), .ADDR_STRAP_IN(strap),
    .SYSTEM_BUS_CLOCK_LINE_IN(scl[0]), .SYSTEM_BUS_DATA_LINE_IN(sda_wire[0]),
    .SYSTEM_BUS_DATA_LINE_OUT(dout[0]), .SYSTEM_BUS_DATA_LINE_OE_OUT(oe[0]),
    .VOLTAGE_SCALING_BUS_CLOCK_LINE_IN(scl[1]), .VOLTAGE_SCALING_BUS_DATA_LINE_IN(sda_wire[1]),
    .VOLTAGE_SCALING_BUS_DATA_LINE_OUT(dout[1]), .VOLTAGE_SCALING_BUS_DATA_LINE_OE_OUT(oe[1]),
    .REG_WR_OUT(wr), .REG_RD_OUT(rd), .REG_INDEX_OUT(idx_o), .REG_WDATA_OUT(wdata),
    .REG_RDATA_IN(rdata), .TARGET_ADDR_OUT(taddr)
  );

  function automatic logic [31:0] next_rand();
    rnd_state ^= rnd_state << 13;
    rnd_state ^= rnd_state >> 17;
    rnd_state ^= rnd_state << 5;
    return rnd_state;
  endfunction

  task automatic check_wr(input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic check_val(input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic close_out();
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Read data follows each port's index, so a slipped index shows up
  always @(posedge core_clk)
  begin
    #1;
    rdata = {idx_o[15:8] ^ key, idx_o[7:0] ^ key};
  end

  // Watchers: oldest note against each write pulse or read byte
  always @(negedge core_clk)
    for (int p = 0; p < 2; p++)
    begin
      if (wr[p] === 1'b1)
        check_wr(wr_q.size() ? wr_q.pop_front() : 24'hx, {p[7:0], idx_o[8*p+:8], wdata[8*p+:8]});
      // Read requests counted per port, checked at the end of each read
      if (rd[p] === 1'b1)
        rd_cnt[p]++;
    end
  always @(got_ev)
    check_val(rd_q.size() ? rd_q.pop_front() : 8'hx, got);

  task automatic wr_xfer(input bit p, input logic [6:0] a, input logic [7:0] i,
                         input logic [7:0] d, input bit spike, input logic ack_exp);
    logic ack;
    host.start_c(p);
    host.wbyte(p, {a, 1'b0}, 1'b0, ack);
    check_val({7'h00, ack_exp}, {7'h00, ack});
    if (ack === 1'b1)
    begin
      host.wbyte(p, i, 1'b0, ack);
      wr_q.push_back({7'h00, p, i, d});
      host.wbyte(p, d, spike, ack);
    end
    host.stop_c(p);
  endtask

  // Index write, repeated start, two reads: acked then refused
  task automatic rd_xfer(input bit p, input logic [6:0] a, input logic [7:0] i);
    logic ack;
    rd_cnt[p] = 0;
    host.start_c(p);
    host.wbyte(p, {a, 1'b0}, 1'b0, ack);
    host.wbyte(p, i, 1'b0, ack);
    host.start_c(p);
    host.wbyte(p, {a, 1'b1}, 1'b0, ack);
    rd_q.push_back(i ^ key);
    host.rbyte(p, 1'b1, got);
    ->got_ev;
    rd_q.push_back(8'(i + 8'h01) ^ key);
    host.rbyte(p, 1'b0, got);
    ->got_ev;
    host.stop_c(p);
    // One request on the read address, one on the host ack, none on the nack
    check_val(8'h02, 8'(rd_cnt[p]));
  endtask

  // Hang guard: longest run is about two milliseconds
  initial
  begin
    #2400us;
    err_total++;
    close_out();
  end

  initial
  begin
    repeat (2) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    #500us;
    key = 8'(next_rand());
    for (int m = 0; m < 4; m++)
    begin
      strap_mode = 2'(m);
      addr = 7'h60 + 7'(m);
      wr_xfer(1'b0, addr, 8'(next_rand()), 8'(next_rand()), m[0], 1'b1);
      check_val({1'b0, addr}, {1'b0, taddr});
      wr_xfer(1'b1, addr, 8'(next_rand()), 8'(next_rand()), 1'b0, 1'b1);
      wr_xfer(1'b1, addr ^ 7'h02, 8'(next_rand()), 8'(next_rand()), 1'b0, 1'b0);
    end
    // High speed first with no master code, then fast and standard
    foreach (half_tab[k])
    begin
      host.half_ns = half_tab[k];
      wr_xfer(k[0], addr, 8'(next_rand()), 8'(next_rand()), 1'b0, 1'b1);
      rd_xfer(~k[0], addr, 8'(next_rand()));
    end
    check_val(8'h00, 8'(wr_q.size() + rd_q.size()));
    close_out();
  end
endmodule // tb
`default_nettype wire

/* verif/two_bus_host_model.sv */
// Behavioural host controller for both serial ports of the target
`timescale 1ns/10ps
`default_nettype none
module two_bus_host_model (
  output logic [1:0]      scl_out,
  output logic [1:0]      sda_low_out,
  input  wire logic [1:0] sda_in
);
  // Half period per speed mode; low phase is two halves so slow acks settle
  int half_ns = 100;

  // Idle: clock stands high, data released to the pull-up
  initial
  begin
    scl_out     = 2'h3;
    sda_low_out = 2'h0;
  end

  // Start or repeated start: data falls while the clock is high
  task automatic start_c(input int p);
    sda_low_out[p] = 1'b0;
    #(2 * half_ns);
    scl_out[p] = 1'b1;
    #(half_ns);
    sda_low_out[p] = 1'b1;
    #(half_ns);
    scl_out[p] = 1'b0;
  endtask

  task automatic stop_c(input int p);
    #(half_ns);
    sda_low_out[p] = 1'b1;
    #(half_ns);
    scl_out[p] = 1'b1;
    #(half_ns);
    sda_low_out[p] = 1'b0;
    #(half_ns);
  endtask

  // One bit; the optional spike is far narrower than the filter
  task automatic put_bit(input int p, input logic b, input bit spike, output logic r);
    #(half_ns);
    sda_low_out[p] = ~b;
    if (spike)
    begin
      #5;
      scl_out[p] = 1'b1;
      #20;
      scl_out[p] = 1'b0;
    end
    #(half_ns);
    scl_out[p] = 1'b1;
    #(half_ns / 2);
    r = sda_in[p];
    #(half_ns / 2);
    scl_out[p] = 1'b0;
  endtask

  // Bytes go most significant bit first
  task automatic wbyte(input int p, input logic [7:0] d, input bit spike, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      put_bit(p, d[i], spike && (i == 7), r);
    put_bit(p, 1'b1, 1'b0, r);
    ack = ~r;
  endtask

  task automatic rbyte(input int p, input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++)
    begin
      put_bit(p, 1'b1, 1'b0, r);
      d = {d[6:0], r};
    end
    put_bit(p, ~ack, 1'b0, r);
  endtask
endmodule // two_bus_host_model
`default_nettype wire
